// *** bench/pixel_source.sv ***
// behavioural video source driving the pixel link
`timescale 1ns/1ps
`default_nettype none
module pixel_source
(
    // pixel link
    output var logic        pixel_clk,
    output var logic [23:0] word,
    output var logic        vsync,
    output var logic        hsync,
    output var logic        valid,
    output var logic        mask
);
    initial pixel_clk = 1'b0;
    // one link cycle; clock stands still between calls; mask rides with the syncs
    task automatic send(input logic [23:0] w, input logic v, input logic s);
        {word, valid, vsync, hsync, mask} = {w, v, s, s, s};
        #3 pixel_clk = 1'b1;
        #2 {word, valid, vsync, hsync, mask} = {~w, 4'b0000};
        #1 pixel_clk = 1'b0;
    endtask : send
endmodule : pixel_source
`default_nettype wire

// *** bench/pvip_properties.sv ***
// concurrent checks on the outputs of the video input port
`timescale 1ns/1ps
`default_nettype none
module pvip_checker
(
    // system clock, reset and output side
    input wire logic                    clk,
    input wire logic                    reset_n,
    input wire video_in_pkg::bus_mode_t bus_mode,
    input wire logic                    pix_out_valid,
    input wire logic                    pix_out_ready,
    input wire video_in_pkg::pixel_t    pix_out,
    input wire logic                    fifo_overflow
);
    import video_in_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // stalled word, and words delivered in the two narrow rgb modes
    wire logic stall = pix_out_valid && !pix_out_ready;
    wire logic p565  = pix_out_valid && bus_mode == MODE_RGB565;
    wire logic p666  = pix_out_valid && bus_mode == MODE_RGB666;
    hold_data_a: assert property (stall |=> $stable(pix_out))
        else $error("word changed under stall");
    hold_valid_a: assert property (stall |=> pix_out_valid)
        else $error("word lost under stall");
    overflow_sticky_a: assert property (fifo_overflow |=> fifo_overflow)
        else $error("overflow flag cleared");
    red_565_a: assert property (p565 |-> pix_out.ch0[2:0] == pix_out.ch0[7:5])
        else $error("red 565 fill wrong");
    green_565_a: assert property (p565 |-> pix_out.ch1[1:0] == pix_out.ch1[7:6])
        else $error("green 565 fill wrong");
    blue_565_a: assert property (p565 |-> pix_out.ch2[2:0] == pix_out.ch2[7:5])
        else $error("blue 565 fill wrong");
    red_666_a: assert property (p666 |-> pix_out.ch0[1:0] == pix_out.ch0[7:6])
        else $error("red 666 fill wrong");
    blue_666_a: assert property (p666 |-> pix_out.ch2[1:0] == pix_out.ch2[7:6])
        else $error("blue 666 fill wrong");
    cover property (stall);
    cover property (p565);
    cover property ($rose(fifo_overflow));
endmodule : pvip_checker
bind parallel_video_input_port pvip_checker chk (.*);
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the parallel video input port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import video_in_pkg::*;
    logic      clk = 1'b0, reset_n = 1'b0, pix_out_ready = 1'b0;
    bus_mode_t bus_mode = MODE_RGB888;
    logic      pixel_clk, vsync, hsync, valid, mask, pix_out_valid, fifo_overflow;
    logic [23:0] word, wq[$];
    pixel_t    pix_out, last, first;
    int        num_errors = 0, comparisons = 0, n;
    pixel_source src (.pixel_clk(pixel_clk), .word(word), .vsync(vsync), .hsync(hsync),
        .valid(valid), .mask(mask));
    parallel_video_input_port dut (.clk(clk), .reset_n(reset_n), .bus_mode(bus_mode),
        .pixel_clk(pixel_clk), .pixel_word_in(word), .vsync_in(vsync), .hsync_in(hsync),
        .pixel_valid_in(valid), .pixel_bus_mask(mask), .pix_out_valid(pix_out_valid),
        .pix_out_ready(pix_out_ready), .pix_out(pix_out), .fifo_overflow(fifo_overflow));
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // accept output words for a while, keep the first and the last one
    task automatic drain();
        n = 0;
        @(negedge clk) pix_out_ready = 1'b1;
        repeat (60) begin
            @(posedge clk);
            if (pix_out_valid === 1'b1) begin
                n++;
                if (n == 1) first = pix_out;
                last = pix_out;
            end
        end
    endtask : drain
    // wq sent as valid words, then invalid all-ones words that must vanish
    task automatic run(input bus_mode_t m, input logic [23:0] e, input logic [2:0] f,
        input string what);
        @(negedge clk) bus_mode = m;
        repeat (4) src.send(24'h0, 1'b0, 1'b0);
        foreach (wq[i]) src.send(wq[i], 1'b1, i == 0);
        repeat (4) src.send(24'hffffff, 1'b0, 1'b0);
        drain();
        check({what, " count"}, 24'h2, 24'(n));
        check({what, " pixel"}, e, {last.ch0, last.ch1, last.ch2});
        check({what, " flags1"}, {21'h0, f}, {21'h0, first.sof, first.sol, first.masked});
        check({what, " flags2"}, 24'h0, {21'h0, last.sof, last.sol, last.masked});
        check({what, " overflow"}, 24'h0, {23'h0, fifo_overflow});
        $display("%s done", what);
    endtask : run
    // burst into a stalled receiver until the fifo refuses
    task automatic t_stall();
        @(negedge clk) pix_out_ready = 1'b0;
        for (int i = 1; i <= 16; i++) src.send({3{8'(i)}}, 1'b1, 1'b0);
        repeat (3) src.send(24'h0, 1'b0, 1'b0);
        repeat (10) @(negedge clk);
        check("overflow", 24'h1, {23'h0, fifo_overflow});
        check("held word", 24'h010101, {pix_out.ch0, pix_out.ch1, pix_out.ch2});
        drain();
        $display("stall done");
    endtask : t_stall
    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    initial forever #25 clk = ~clk;
    initial begin
        #100us num_errors++;
        give_verdict();
    end
    initial begin
        repeat (10) src.send(24'h0, 1'b0, 1'b0);
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        wq = '{24'ha5b365, 24'ha5b365};
        run(MODE_RGB565, 24'hb56d29, 3'h7, "rgb565");
        wq = '{24'hfed4f8, 24'hfed4f8};
        run(MODE_RGB666, 24'hb64de3, 3'h7, "rgb666");
        wq = '{24'hff8040, 24'h0081c0};
        run(MODE_YCC422, 24'h8140c0, 3'h7, "ycc422");
        wq = '{24'h5a5aff, 24'h5a5a00, 24'h5a5a00, 24'h5a5a80, 24'h5a5a11, 24'h5a5a22,
            24'h5a5a33, 24'h5a5a44};
        run(MODE_BT656, 24'h441133, 3'h2, "bt656");
        wq = '{24'h3c5a96, 24'h3c5a96};
        run(MODE_RGB888, 24'h3c5a96, 3'h7, "rgb888");
        t_stall();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire

// *** design/parallel_video_input_port.sv ***
// parallel video input port: pixel-clock capture, decode, crossing, output
//
// Contract
// - all pins sampled on the source pixel clock
// - pixels accepted only while valid qualifier high
// - vertical/horizontal syncs mark frame and line starts
// - selectable bus widths 8, 16, 18, 24
// - 24-bit mode gives three 8-bit channels
// - 565 mode fields mapped then expanded to 888
// - 666 mode fields mapped then expanded to 888
// - luma/chroma 4:2:2 converted to internal pixels
// - 8-bit mode with embedded timing references
`timescale 1ns/1ps
`default_nettype none
module parallel_video_input_port
(
    // system clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // configuration, system clock domain
    input  wire video_in_pkg::bus_mode_t bus_mode,
    // pixel link, pixel clock domain
    input  wire logic                    pixel_clk,
    input  wire logic [23:0]             pixel_word_in,
    input  wire logic                    vsync_in,
    input  wire logic                    hsync_in,
    input  wire logic                    pixel_valid_in,
    input  wire logic                    pixel_bus_mask,
    // received pixel stream, system clock domain
    output logic                         pix_out_valid,
    input  wire logic                    pix_out_ready,
    output video_in_pkg::pixel_t         pix_out,
    // status, system clock domain
    output logic                         fifo_overflow
);
    import video_in_pkg::*;

    // ********************************************************************
    // channel expansion helpers
    // ********************************************************************

    // 5-bit field to 8 bits by repeating the top bits
    function automatic logic [CH_W-1:0] expand5(input logic [4:0] v);
        expand5 = {v, v[4:2]};
    endfunction : expand5

    // 6-bit field to 8 bits by repeating the top bits
    function automatic logic [CH_W-1:0] expand6(input logic [5:0] v);
        expand6 = {v, v[5:4]};
    endfunction : expand6

    // ********************************************************************
    // pixel clock domain state
    // ********************************************************************
    typedef struct packed {
        pins_t            pin_q;                 // pins captured this edge
        bus_mode_t        mode_s1;               // mode synchroniser stage 1
        bus_mode_t        mode_s2;               // mode synchroniser stage 2
        logic             vsync_prev;            // vsync one edge ago
        logic             hsync_prev;            // hsync one edge ago
        logic             sof_pend;              // frame start not yet tagged
        logic             sol_pend;              // line start not yet tagged
        logic             chroma_phase;          // 4:2:2 next chroma is cr
        logic [CH_W-1:0]  cb_hold;               // latest blue difference
        logic [CH_W-1:0]  cr_hold;               // latest red difference
        bt_state_t        bt_state;              // preamble tracker
        logic             bt_active;             // inside active video
        logic             bt_vblank;             // last code said blanking
        logic [1:0]       bt_phase;              // cb, y, cr, y sequence
        logic [FIFO_AW:0] wptr_bin;              // write pointer, binary
        logic [FIFO_AW:0] wptr_gray;             // write pointer, gray
        logic [FIFO_AW:0] rptr_s1;               // read pointer sync stage 1
        logic [FIFO_AW:0] rptr_s2;               // read pointer sync stage 2
        logic             overflow;              // a pixel found fifo full
    } link_state_t;

    localparam link_state_t LINK_RESET = '{
        pin_q:        '0,
        mode_s1:      MODE_RESET,
        mode_s2:      MODE_RESET,
        vsync_prev:   1'b0,
        hsync_prev:   1'b0,
        sof_pend:     1'b0,
        sol_pend:     1'b0,
        chroma_phase: 1'b0,
        cb_hold:      '0,
        cr_hold:      '0,
        bt_state:     BT_DATA,
        bt_active:    1'b0,
        bt_vblank:    1'b0,
        bt_phase:     2'h0,
        wptr_bin:     '0,
        wptr_gray:    '0,
        rptr_s1:      '0,
        rptr_s2:      '0,
        overflow:     1'b0
    };

    link_state_t     lk;                         // registered link state
    link_state_t     next_lk;                    // next link state
    logic            link_rst_meta;              // link reset sync stage 1
    logic            link_rst_n;                 // link reset, released on pixel_clk
    logic            wr_en;                      // write a pixel this edge
    pixel_t          wr_px;                      // pixel being written
    pixel_t          fifo_mem [FIFO_DEP];        // crossing storage
    logic [FIFO_AW:0] rptr_gray;                 // read pointer seen by link side

    // ********************************************************************
    // system clock domain state
    // ********************************************************************
    typedef struct packed {
        logic [FIFO_AW:0] rptr_bin;              // read pointer, binary
        logic [FIFO_AW:0] rptr_gray;             // read pointer, gray
        logic [FIFO_AW:0] wptr_s1;               // write pointer sync stage 1
        logic [FIFO_AW:0] wptr_s2;               // write pointer sync stage 2
        logic             ovf_s1;                // overflow sync stage 1
        logic             ovf_s2;                // overflow sync stage 2
    } sys_state_t;

    sys_state_t      sy;                         // registered system state
    sys_state_t      next_sy;                    // next system state
    logic            fifo_empty;                 // nothing to drain
    logic            buf_in_ready;               // buffer can take a word
    logic            rd_en;                      // move a word to the buffer

    // ********************************************************************
    // link reset: asserted at once, released on the pixel clock
    // ********************************************************************

    // two-stage release so the link logic leaves reset cleanly
    always_ff @(posedge pixel_clk or negedge reset_n) begin
        if (!reset_n) begin
            link_rst_meta <= 1'b0;
            link_rst_n    <= 1'b0;
        end else begin
            link_rst_meta <= 1'b1;
            link_rst_n    <= link_rst_meta;
        end
    end

    // ********************************************************************
    // link side: capture, sync tracking, decode, fifo write
    // ********************************************************************

    assign rptr_gray = sy.rptr_gray;

    // next link state and the pixel to write
    always_comb begin
        logic            vs_rise;                // frame sync edge
        logic            hs_rise;                // line sync edge
        logic            px_ok;                  // a pixel is decoded
        logic            fifo_full;              // no room for a pixel
        logic [CH_W-1:0] bt_byte;                // 8-bit mode byte
        logic [CH_W-1:0] c422;                   // 4:2:2 chroma byte
        pins_t           p;                      // captured pins
        vs_rise   = 1'b0;
        hs_rise   = 1'b0;
        px_ok     = 1'b0;
        fifo_full = 1'b0;
        bt_byte   = '0;
        c422      = '0;
        p         = lk.pin_q;
        next_lk   = lk;
        wr_en     = 1'b0;
        wr_px     = PIXEL_RESET;

        // every pin is registered on the pixel clock before use
        next_lk.pin_q = '{word: pixel_word_in, vsync: vsync_in, hsync: hsync_in,
                          valid: pixel_valid_in, mask: pixel_bus_mask};
        next_lk.mode_s1 = bus_mode;
        next_lk.mode_s2 = lk.mode_s1;
        next_lk.rptr_s1 = rptr_gray;
        next_lk.rptr_s2 = lk.rptr_s1;

        // separate syncs locate frames and lines, except in 8-bit mode
        vs_rise = p.vsync & ~lk.vsync_prev;
        hs_rise = p.hsync & ~lk.hsync_prev;
        next_lk.vsync_prev = p.vsync;
        next_lk.hsync_prev = p.hsync;
        if (lk.mode_s2 != MODE_BT656) begin
            if (vs_rise) begin
                next_lk.sof_pend = 1'b1;
            end
            if (hs_rise) begin
                next_lk.sol_pend     = 1'b1;
                next_lk.chroma_phase = 1'b0;
            end
        end

        // decode the captured word by bus mode
        wr_px.masked = p.mask;
        case (lk.mode_s2)
            MODE_RGB888: begin
                px_ok     = p.valid;
                wr_px.ch0 = p.word[R888_LSB +: CH_W];
                wr_px.ch1 = p.word[G888_LSB +: CH_W];
                wr_px.ch2 = p.word[B888_LSB +: CH_W];
            end
            MODE_RGB666: begin
                px_ok     = p.valid;
                wr_px.ch0 = expand6(p.word[R666_LSB +: 6]);
                wr_px.ch1 = expand6(p.word[G666_LSB +: 6]);
                wr_px.ch2 = expand6(p.word[B666_LSB +: 6]);
            end
            MODE_RGB565: begin
                px_ok     = p.valid;
                wr_px.ch0 = expand5(p.word[R565_LSB +: 5]);
                wr_px.ch1 = expand6(p.word[G565_LSB +: 6]);
                wr_px.ch2 = expand5(p.word[B565_LSB +: 5]);
            end
            MODE_YCC422: begin
                // chroma alternates cb then cr; each pixel keeps the newest pair
                px_ok = p.valid;
                c422  = p.word[C422_LSB +: CH_W];
                if (p.valid) begin
                    if (!lk.chroma_phase || hs_rise) begin
                        next_lk.cb_hold = c422;
                    end else begin
                        next_lk.cr_hold = c422;
                    end
                    next_lk.chroma_phase = ~lk.chroma_phase | hs_rise;
                end
                wr_px.ch0 = p.word[Y422_LSB +: CH_W];
                wr_px.ch1 = next_lk.cb_hold;
                wr_px.ch2 = next_lk.cr_hold;
            end
            MODE_BT656: begin
                // preamble ff 00 00 then xy code; active bytes run cb y cr y
                bt_byte = p.word[BT_LSB +: CH_W];
                if (p.valid) begin
                    case (lk.bt_state)
                        BT_GOT_FF: begin
                            next_lk.bt_state = (bt_byte == TRS_00) ? BT_GOT_Z1 : BT_DATA;
                        end
                        BT_GOT_Z1: begin
                            next_lk.bt_state = (bt_byte == TRS_00) ? BT_GOT_Z2 : BT_DATA;
                        end
                        BT_GOT_Z2: begin
                            // xy code: start of active video opens a line
                            next_lk.bt_state  = BT_DATA;
                            next_lk.bt_vblank = bt_byte[XY_V_BIT];
                            next_lk.bt_active = ~bt_byte[XY_H_BIT] & ~bt_byte[XY_V_BIT];
                            if (!bt_byte[XY_H_BIT] && !bt_byte[XY_V_BIT]) begin
                                next_lk.bt_phase = 2'h0;
                                next_lk.sol_pend = 1'b1;
                                if (lk.bt_vblank) begin
                                    next_lk.sof_pend = 1'b1;
                                end
                            end
                        end
                        default: begin
                            if (bt_byte == TRS_FF) begin
                                next_lk.bt_state = BT_GOT_FF;
                            end else if (lk.bt_active) begin
                                next_lk.bt_phase = lk.bt_phase + 2'h1;
                                if (lk.bt_phase == 2'h0) begin
                                    next_lk.cb_hold = bt_byte;
                                end else if (lk.bt_phase == 2'h2) begin
                                    next_lk.cr_hold = bt_byte;
                                end else begin
                                    px_ok = 1'b1;          // luma byte gives a pixel
                                end
                            end
                        end
                    endcase
                end
                wr_px.ch0 = bt_byte;
                wr_px.ch1 = lk.cb_hold;
                wr_px.ch2 = lk.cr_hold;
            end
            default: begin
                px_ok = 1'b0;                    // unused code takes nothing
            end
        endcase

        // write the pixel, or note that it had no room
        fifo_full = (lk.wptr_gray == {~lk.rptr_s2[FIFO_AW:FIFO_AW-1],
                                      lk.rptr_s2[FIFO_AW-2:0]});
        if (px_ok) begin
            if (fifo_full) begin
                next_lk.overflow = 1'b1;         // sticky until reset
            end else begin
                wr_en             = 1'b1;
                wr_px.sof         = next_lk.sof_pend;
                wr_px.sol         = next_lk.sol_pend;
                next_lk.sof_pend  = 1'b0;
                next_lk.sol_pend  = 1'b0;
                next_lk.wptr_bin  = lk.wptr_bin + 1'b1;
                next_lk.wptr_gray = bin2gray(next_lk.wptr_bin);
            end
        end
    end

    // link state register
    always_ff @(posedge pixel_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            lk <= LINK_RESET;
        end else begin
            lk <= next_lk;
        end
    end

    // crossing storage, written on the pixel clock only
    always_ff @(posedge pixel_clk) begin
        if (wr_en) begin
            fifo_mem[lk.wptr_bin[FIFO_AW-1:0]] <= wr_px;
        end
    end

    // ********************************************************************
    // system side: fifo drain into the two-entry buffer
    // ********************************************************************

    // words pass only when the buffer can take them, so a stall fills the fifo
    always_comb begin
        next_sy         = sy;
        next_sy.wptr_s1 = lk.wptr_gray;
        next_sy.wptr_s2 = sy.wptr_s1;
        next_sy.ovf_s1  = lk.overflow;
        next_sy.ovf_s2  = sy.ovf_s1;
        fifo_empty      = (sy.rptr_gray == sy.wptr_s2);
        rd_en           = ~fifo_empty & buf_in_ready;
        if (rd_en) begin
            next_sy.rptr_bin  = sy.rptr_bin + 1'b1;
            next_sy.rptr_gray = bin2gray(next_sy.rptr_bin);
        end
    end

    // system state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sy <= '0;
        end else begin
            sy <= next_sy;
        end
    end

    // output buffer absorbs a stall by the receiver
    pix_skid_buffer u_out_buf (
        .clk       (clk),
        .reset_n   (reset_n),
        .in_valid  (rd_en),
        .in_data   (fifo_mem[sy.rptr_bin[FIFO_AW-1:0]]),
        .in_ready  (buf_in_ready),
        .out_valid (pix_out_valid),
        .out_ready (pix_out_ready),
        .out_data  (pix_out)
    );

    // overflow status straight from its second sync stage
    assign fifo_overflow = sy.ovf_s2;

endmodule : parallel_video_input_port
`default_nettype wire

// *** design/pix_skid_buffer.sv ***
// two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module pix_skid_buffer
(
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // filling side
    input  wire logic                 in_valid,
    input  wire video_in_pkg::pixel_t in_data,
    output logic                      in_ready,
    // draining side
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output video_in_pkg::pixel_t      out_data
);
    import video_in_pkg::*;

    // ********************************************************************
    // state
    // ********************************************************************
    typedef struct packed {
        logic   valid0;                          // head entry holds a word
        logic   valid1;                          // second entry holds a word
        pixel_t e0;                              // head entry
        pixel_t e1;                              // second entry
    } buf_state_t;

    buf_state_t st;                              // registered state
    buf_state_t next_st;                         // next state

    // outputs straight from the registers
    assign in_ready  = ~st.valid1;
    assign out_valid = st.valid0;
    assign out_data  = st.e0;

    // shift on pop, then place the pushed word in the first free entry
    always_comb begin
        next_st = st;
        if (st.valid0 && out_ready) begin
            next_st.e0     = st.e1;
            next_st.valid0 = st.valid1;
            next_st.valid1 = 1'b0;
        end
        if (in_valid && !st.valid1) begin
            if (!next_st.valid0) begin
                next_st.e0     = in_data;
                next_st.valid0 = 1'b1;
            end else begin
                next_st.e1     = in_data;
                next_st.valid1 = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{valid0: 1'b0, valid1: 1'b0, e0: PIXEL_RESET, e1: PIXEL_RESET};
        end else begin
            st <= next_st;
        end
    end

endmodule : pix_skid_buffer
`default_nettype wire

// *** pkg/video_in_pkg.sv ***
// shared types and constants of the parallel video input port
package video_in_pkg;

    // ********************************************************************
    // widths and buffer geometry
    // ********************************************************************
    localparam int BUS_W    = 24;                // pixel bus width
    localparam int CH_W     = 8;                 // internal channel width
    localparam int FIFO_AW  = 3;                 // crossing fifo address bits
    localparam int FIFO_DEP = 1 << FIFO_AW;      // crossing fifo depth

    // ********************************************************************
    // bus field positions (lsb of each channel on the pixel bus)
    // ********************************************************************
    localparam int R888_LSB = 16;
    localparam int G888_LSB = 8;
    localparam int B888_LSB = 0;
    localparam int R666_LSB = 12;
    localparam int G666_LSB = 6;
    localparam int B666_LSB = 0;
    localparam int R565_LSB = 11;
    localparam int G565_LSB = 5;
    localparam int B565_LSB = 0;
    localparam int Y422_LSB = 8;                 // luma byte, 16-bit 4:2:2
    localparam int C422_LSB = 0;                 // chroma byte, 16-bit 4:2:2
    localparam int BT_LSB   = 0;                 // byte lane of the 8-bit mode

    // ********************************************************************
    // embedded timing reference codes
    // ********************************************************************
    localparam logic [7:0] TRS_FF   = 8'hff;     // first preamble byte
    localparam logic [7:0] TRS_00   = 8'h00;     // second and third bytes
    localparam int         XY_V_BIT = 5;         // vertical blanking flag
    localparam int         XY_H_BIT = 4;         // 1 = end of active video

    // ********************************************************************
    // modes, states and carriers
    // ********************************************************************
    typedef enum logic [2:0] {
        MODE_RGB888,                             // 24-bit rgb 8:8:8
        MODE_RGB666,                             // 18-bit rgb 6:6:6
        MODE_RGB565,                             // 16-bit rgb 5:6:5
        MODE_YCC422,                             // 16-bit luma/chroma 4:2:2
        MODE_BT656                               // 8-bit embedded timing
    } bus_mode_t;

    localparam bus_mode_t MODE_RESET = MODE_RGB888;

    typedef enum logic [1:0] {
        BT_DATA,                                 // ordinary byte expected
        BT_GOT_FF,                               // preamble byte 1 seen
        BT_GOT_Z1,                               // preamble byte 2 seen
        BT_GOT_Z2                                // next byte is the xy code
    } bt_state_t;

    typedef struct packed {
        logic [BUS_W-1:0] word;                  // pixel word
        logic             vsync;                 // frame sync
        logic             hsync;                 // line sync
        logic             valid;                 // data valid qualifier
        logic             mask;                  // data mask
    } pins_t;

    typedef struct packed {
        logic            sof;                    // first pixel of a frame
        logic            sol;                    // first pixel of a line
        logic            masked;                 // mask was high with it
        logic [CH_W-1:0] ch0;                    // red or luma
        logic [CH_W-1:0] ch1;                    // green or cb
        logic [CH_W-1:0] ch2;                    // blue or cr
    } pixel_t;

    localparam pixel_t PIXEL_RESET = '0;

    // binary to gray for the crossing pointers
    function automatic logic [FIFO_AW:0] bin2gray(input logic [FIFO_AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

endpackage : video_in_pkg
